// *** hdl/pm1_event_pkg.sv ***
// pm1 event block constants: host offsets, controller addresses, bit positions, resets.
// assumes byte-wide host i/o decode already qualified by the block select.
package pm1_event_pkg;

    // host i/o offsets from block base
    localparam logic [2:0] host_status_one = 3'h0;
    localparam logic [2:0] host_status_two = 3'h1;
    localparam logic [2:0] host_enable_one = 3'h2;
    localparam logic [2:0] host_enable_two = 3'h3;
    localparam logic [2:0] host_control_one = 3'h4;
    localparam logic [2:0] host_control_two = 3'h5;

    // controller memory-mapped addresses
    localparam logic [15:0] ec_status_two = 16'h7F80;
    localparam logic [15:0] ec_enable_two = 16'h7F81;
    localparam logic [15:0] ec_control_two = 16'h7F82;
    localparam logic [15:0] ec_firmware_pm = 16'h7F83;

    // status bit positions
    localparam int power_button_bit = 0;
    localparam int sleep_button_bit = 1;
    localparam int clock_event_bit = 2;
    localparam int override_bit = 3;
    localparam int wake_bit = 7;

    // control two bit positions
    localparam int override_enable_bit = 1;
    localparam int sleep_type_lsb = 2;
    localparam int sleep_trigger_bit = 5;

    // implemented bits
    localparam logic [7:0] status_two_mask = 8'h8F;
    localparam logic [7:0] enable_two_mask = 8'h07;
    localparam logic [7:0] control_two_mask = 8'h1E;

    localparam logic [7:0] reset_value = 8'h00;

endpackage

// *** hdl/pm1_reset_sync.sv ***
// two-stage release of the asynchronous reset.
// assumes rst_n may drop at any time; release is aligned to core_clk.
`timescale 1ns/1ns
module pm1_reset_sync (
    // clock and raw reset
    input wire logic core_clk,
    input wire logic rst_n,
    // synchronised reset
    output logic sync_rst_n
);
    logic first_stage;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_stage <= 1'b0;
            sync_rst_n <= 1'b0;
        end else begin
            first_stage <= 1'b1;
            sync_rst_n <= first_stage;
        end
    end
endmodule // pm1_reset_sync

// *** hdl/acpi_pm1_event_block_sci.sv ***
// pm1 event register block with sci request pin.
// host side: byte i/o with a one-cycle strobe, offset already decoded from base.
// controller side: byte memory access with a one-cycle strobe; reads answer one cycle later.
`timescale 1ns/1ns
module acpi_pm1_event_block_sci (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // host i/o port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [2:0] host_offset,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // controller memory port
    input wire logic ec_sel,
    input wire logic ec_wr,
    input wire logic ec_rd,
    input wire logic [15:0] ec_addr,
    input wire logic [7:0] ec_wdata,
    output logic [7:0] ec_rdata,
    output logic ec_hit,
    output logic ec_irq,
    // pin and decoded fields
    output logic sci_request_n,
    output logic [2:0] sleep_type_field,
    output logic sleep_trigger
);
    typedef struct packed {
        logic [7:0] status_two;
        logic [2:0] enable_two;
        logic override_enable;
        logic [2:0] sleep_type;
        logic trigger;
        logic firmware_sci_flag;
        logic [7:0] host_rdata;
        logic [7:0] ec_rdata;
        logic ec_hit;
        logic ec_irq;
        logic sci_n;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic sync_rst_n;

    pm1_reset_sync reset_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sync_rst_n(sync_rst_n)
    );

    logic host_write;
    logic host_read;
    logic ec_write;
    logic ec_read;
    logic [7:0] enable_view;
    logic [7:0] control_view;
    logic [7:0] firmware_view;
    logic pending;

    assign host_write = host_sel && host_wr;
    assign host_read = host_sel && host_rd;
    assign ec_write = ec_sel && ec_wr;
    assign ec_read = ec_sel && ec_rd;

    assign enable_view = {5'h0, cur.enable_two};
    assign firmware_view = {7'h0, cur.firmware_sci_flag};
    assign control_view = {2'h0, cur.trigger, cur.sleep_type, cur.override_enable, 1'b0};

    always_comb begin
        next_cur = cur;
        next_cur.ec_irq = 1'b0;
        next_cur.ec_hit = 1'b0;

        // controller load first, host clear after
        if (ec_write && ec_addr == pm1_event_pkg::ec_status_two) begin
            next_cur.status_two = ec_wdata & pm1_event_pkg::status_two_mask;
        end
        if (host_write && host_offset == pm1_event_pkg::host_status_two) begin
            next_cur.status_two = next_cur.status_two & ~(host_wdata & pm1_event_pkg::status_two_mask);
        end

        // only the host writes the masks
        if (host_write && host_offset == pm1_event_pkg::host_enable_two) begin
            next_cur.enable_two = host_wdata[2:0];
        end

        if (host_write && host_offset == pm1_event_pkg::host_control_two) begin
            // override and sleep type from host
            next_cur.override_enable = host_wdata[pm1_event_pkg::override_enable_bit];
            next_cur.sleep_type = host_wdata[pm1_event_pkg::sleep_type_lsb +: 3];
        end

        if (ec_write && ec_addr == pm1_event_pkg::ec_control_two && ec_wdata[pm1_event_pkg::sleep_trigger_bit]) begin
            next_cur.trigger = 1'b0;
        end
        // host set wins over same-cycle clear
        if (host_write && host_offset == pm1_event_pkg::host_control_two &&
            host_wdata[pm1_event_pkg::sleep_trigger_bit]) begin
            next_cur.trigger = 1'b1;
        end

        if (ec_write && ec_addr == pm1_event_pkg::ec_firmware_pm) begin
            next_cur.firmware_sci_flag = ec_wdata[0];
        end

        // any host write to these interrupts
        if (host_write && (host_offset == pm1_event_pkg::host_status_two ||
            host_offset == pm1_event_pkg::host_enable_two ||
            host_offset == pm1_event_pkg::host_control_two)) begin
            next_cur.ec_irq = 1'b1;
        end

        // host read data, held until next read
        if (host_read) begin
            unique case (host_offset)
                pm1_event_pkg::host_status_two: next_cur.host_rdata = cur.status_two & pm1_event_pkg::status_two_mask;
                pm1_event_pkg::host_enable_two: next_cur.host_rdata = enable_view;
                pm1_event_pkg::host_control_two: next_cur.host_rdata = control_view & pm1_event_pkg::control_two_mask;
                default: next_cur.host_rdata = 8'h00;
            endcase
        end

        // controller read data with hit flag
        if (ec_read) begin
            next_cur.ec_hit = 1'b1;
            unique case (ec_addr)
                pm1_event_pkg::ec_status_two: next_cur.ec_rdata = cur.status_two & pm1_event_pkg::status_two_mask;
                pm1_event_pkg::ec_enable_two: next_cur.ec_rdata = enable_view;
                pm1_event_pkg::ec_control_two: next_cur.ec_rdata = control_view;
                pm1_event_pkg::ec_firmware_pm: next_cur.ec_rdata = firmware_view;
                default: begin
                    next_cur.ec_rdata = 8'h00;
                    next_cur.ec_hit = 1'b0;
                end
            endcase
        end

        // enabled event flags pull sci low
        pending = |(next_cur.status_two[2:0] & next_cur.enable_two) || next_cur.firmware_sci_flag;
        next_cur.sci_n = ~pending;
    end

    // everything clears on reset; pin idles high
    always_ff @(posedge core_clk or negedge sync_rst_n) begin
        if (!sync_rst_n) begin
            cur <= '0;
            cur.sci_n <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign host_rdata = cur.host_rdata;
    assign ec_rdata = cur.ec_rdata;
    assign ec_hit = cur.ec_hit;
    assign ec_irq = cur.ec_irq;
    assign sci_request_n = cur.sci_n;
    assign sleep_type_field = cur.sleep_type;
    assign sleep_trigger = cur.trigger;
endmodule // acpi_pm1_event_block_sci

// *** test/pm1_host.sv ***
// host chipset model: one-cycle i/o strobes on the host port.
// assumes the bench waits out reset first.
`timescale 1ns/1ns
module pm1_host (
    // clock
    input wire logic core_clk,
    // host i/o cycle
    output logic host_sel,
    output logic host_wr,
    output logic host_rd,
    output logic [2:0] host_offset,
    output logic [7:0] host_wdata
);
    initial {host_sel, host_wr, host_rd, host_offset, host_wdata} = '0;
    task automatic io(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        {host_sel, host_wr, host_rd, host_offset, host_wdata} = {1'b1, w, !w, a, d};
        @(posedge core_clk) #1;
        // released data inverted, never a stale copy
        {host_sel, host_wr, host_rd, host_wdata} = {3'b000, ~d};
    endtask
endmodule // pm1_host

// *** test/pm1_chk.sv ***
// port assertions for the pm1 event block.
// bound to the block; off while raw reset is low.
`timescale 1ns/1ns
module pm1_chk (
    // clock, reset, host port
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [2:0] host_offset,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    // controller port, outputs
    input wire logic ec_sel,
    input wire logic ec_wr,
    input wire logic [15:0] ec_addr,
    input wire logic [7:0] ec_wdata,
    input wire logic ec_irq,
    input wire logic sci_request_n,
    input wire logic [2:0] sleep_type_field,
    input wire logic sleep_trigger
);
    wire hw = host_sel && host_wr;
    wire hr = host_sel && host_rd;
    wire odd_reg = host_offset[0] && host_offset != 3'h7;
    wire ctl_wr = hw && host_offset == 3'h5;
    wire trig_clr = ec_sel && ec_wr && ec_addr == 16'h7F82 && ec_wdata[5];
    wire fw_set = ec_sel && ec_wr && ec_addr == 16'h7F83 && ec_wdata[0];
    wire [2:0] new_type = host_wdata[4:2];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    irq_write_a: assert property (hw && odd_reg |=> ec_irq) else $error("irq missing");
    irq_cause_a: assert property (ec_irq |-> $past(hw) && $past(odd_reg)) else $error("stray irq");
    trig_set_a: assert property (ctl_wr && host_wdata[5] |=> sleep_trigger) else $error("trigger unset");
    trig_keep_a: assert property (sleep_trigger && !trig_clr |=> sleep_trigger) else $error("trigger lost");
    type_load_a: assert property (ctl_wr |=> sleep_type_field == $past(new_type)) else $error("bad type");
    rsvd_read_a: assert property (hr && !odd_reg |=> host_rdata == 8'h00) else $error("reserved set");
    ctl_read_a: assert property (hr && host_offset == 3'h5 |=> (host_rdata & 8'hE1) == 8'h00) else $error("ctl");
    fw_sci_a: assert property (fw_set |=> !sci_request_n) else $error("sci idle");
    cover property (hw && odd_reg);
    cover property (!sci_request_n);
    cover property (sleep_trigger ##1 !sleep_trigger);
endmodule // pm1_chk
bind acpi_pm1_event_block_sci pm1_chk pm1_chk_inst (.*);

// *** test/tb_acpi_pm1_event_block_sci.sv ***
// self-checking bench for the pm1 event block.
// host cycles via the host model; controller cycles driven here.
`timescale 1ns/1ns
module tb_acpi_pm1_event_block_sci;
    logic core_clk, rst_n, host_sel, host_wr, host_rd, ec_sel, ec_wr, ec_rd, ec_hit, ec_irq;
    logic sci_request_n, sleep_trigger, rd_seen;
    logic [2:0] host_offset, sleep_type_field;
    logic [7:0] host_wdata, host_rdata, ec_wdata, ec_rdata, r, x;
    logic [15:0] ec_addr;
    logic [7:0] qh[$], qe[$];
    int errors = 0;
    int num_checks = 0;
    int bits[5] = '{0, 1, 2, 3, 7};
    pm1_host pm1_host_inst (.*);
    acpi_pm1_event_block_sci acpi_pm1_event_block_sci_inst (.*);
    initial begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic ec(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        {ec_sel, ec_wr, ec_rd, ec_addr, ec_wdata} = {1'b1, w, !w, a, d};
        @(posedge core_clk) #1;
        {ec_sel, ec_wr, ec_rd, ec_wdata} = {3'b000, ~d};
    endtask
    task automatic er(input logic [15:0] a, input logic [7:0] e);
        qe.push_back(e);
        ec(0, a, 8'h00);
    endtask
    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        pm1_host_inst.io(1, a, d);
    endtask
    task automatic hr(input logic [2:0] a, input logic [7:0] e);
        qh.push_back(e);
        pm1_host_inst.io(0, a, 8'h00);
    endtask
    task automatic sci(input logic e);
        @(posedge core_clk) #2;
        chk({7'h00, sci_request_n}, {7'h00, e});
    endtask
    // read data lands one cycle after the strobe
    always @(posedge core_clk) begin
        rd_seen = host_sel && host_rd;
        #2;
        if (rd_seen) chk(host_rdata, qh.pop_front());
        if (ec_hit) chk(ec_rdata, qe.pop_front());
    end
    initial begin
        {rst_n, ec_sel, ec_wr, ec_rd, ec_addr, ec_wdata} = '0;
        void'($urandom(32'h232e5f6c));
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 8; i++) hr(i[2:0], 8'h00);
        repeat (4) begin
            r = 8'($urandom);
            hw(3'h3, r);
            ec(1, 16'h7F81, ~r);
            hr(3'h3, r & 8'h07);
            er(16'h7F81, r & 8'h07);
        end
        ec(1, 16'h7F80, 8'hFF);
        hw(3'h1, 8'h00);
        x = 8'h8F;
        er(16'h7F80, x);
        foreach (bits[i]) begin
            hw(3'h1, 8'h01 << bits[i]);
            x[bits[i]] = 1'b0;
            hr(3'h1, x);
        end
        hw(3'h3, 8'h07);
        for (int i = 0; i < 4; i++) begin
            ec(1, 16'h7F80, 8'h01 << i);
            sci(i == 3);
        end
        hw(3'h3, 8'h00);
        ec(1, 16'h7F80, 8'h07);
        sci(1);
        ec(1, 16'h7F83, 8'h01);
        sci(0);
        er(16'h7F83, 8'h01);
        ec(1, 16'h7F83, 8'h00);
        sci(1);
        hw(3'h5, 8'hFF);
        chk({4'h0, sleep_trigger, sleep_type_field}, 8'h0F);
        hr(3'h5, 8'h1E);
        er(16'h7F82, 8'h3E);
        ec(1, 16'h7F82, 8'h00);
        hw(3'h5, 8'h00);
        er(16'h7F82, 8'h20);
        ec(1, 16'h7F82, 8'h20);
        er(16'h7F82, 8'h00);
        repeat (2) @(posedge core_clk);
        // a read that never answered leaves its note behind
        if (qh.size() != 0 || qe.size() != 0) begin
            errors++;
        end
        tally_and_finish();
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule // tb_acpi_pm1_event_block_sci
